// ---- src/ovs_pkg.sv ----
// Constants, register map and curve tables for the overvoltage stage logic
package ovs_pkg;
    localparam int          VW          = 16;
    localparam int          NSTG        = 3;
    localparam int          NIDMT       = 2;
    localparam int          NPH         = 3;
    // Clock and time base
    localparam real         CLK_HZ      = 20.0e6;
    localparam real         UNIT_S      = 100.0e-6;
    localparam int          UNIT_CYC    = int'(CLK_HZ * UNIT_S);
    localparam real         UNITS_PER_S = 1.0 / UNIT_S;
    // Pickup drop-off at 95 percent of threshold
    localparam int          HYST_NUM    = 19;
    localparam int          HYST_DEN    = 20;
    // Register byte offsets
    localparam logic [7:0]  OFS_GLOBAL  = 8'h00;
    localparam logic [7:0]  OFS_STATUS  = 8'h04;
    localparam logic [1:0]  FLD_CTRL    = 2'h0;
    localparam logic [1:0]  FLD_THRESH  = 2'h1;
    localparam logic [1:0]  FLD_DELAY   = 2'h2;
    localparam logic [1:0]  FLD_MULT    = 2'h3;
    // Control fields
    localparam int          CTL_MODE_LO = 0;
    localparam int          CTL_ALARM   = 4;
    localparam int          CTL_IDMT    = 5;
    localparam int          CTL_CRV_LO  = 8;
    localparam int          CTL_W       = 12;
    localparam int          DLY_W       = 24;
    localparam int          MUL_W       = 16;
    localparam int          MUL_FRAC    = 8;
    // Reset values
    localparam logic [CTL_W-1:0] RST_CTRL   = 12'h000;
    localparam logic [VW-1:0]    RST_THRESH = 16'hFFFF;
    localparam logic [DLY_W-1:0] RST_DELAY  = 24'h000000;
    localparam logic [MUL_W-1:0] RST_MULT   = 16'h0100;

    typedef enum logic [2:0] {
        OVS_OFF     = 3'h0,
        OVS_ANY     = 3'h1,
        OVS_ALL     = 3'h2,
        OVS_ANY_BQ  = 3'h3,
        OVS_ALL_BQ  = 3'h4
    } ovs_mode_t;

    typedef enum logic [3:0] {
        CRV_IEC_SI   = 4'h0,
        CRV_IEC_VI   = 4'h1,
        CRV_IEC_EI   = 4'h2,
        CRV_IEC_LTI  = 4'h3,
        CRV_FR_STI   = 4'h4,
        CRV_IEEE_MI  = 4'h5,
        CRV_IEEE_VI  = 4'h6,
        CRV_IEEE_EI  = 4'h7,
        CRV_US_CO8   = 4'h8,
        CRV_US_STI1  = 4'h9,
        CRV_US_STI2  = 4'hA
    } ovs_curve_t;

    // Ratio bins of one eighth from 1.0 up to 3.0
    localparam int          BIN_N       = 17;
    localparam int          BIN_STEP    = 8;
    localparam int          XW          = 24;
    localparam int          XFRAC       = 16;
    localparam int          KW          = 24;
    localparam int          NUMW        = KW + XFRAC;

    // Exponent codes: 0.02, 0.04, 1, 2
    function automatic logic [4*BIN_N*XW-1:0] ovs_build_x();
        logic [4*BIN_N*XW-1:0] t;
        real                   al [4];
        real                   r;
        t = '0;
        al[0] = 0.02;
        al[1] = 0.04;
        al[2] = 1.0;
        al[3] = 2.0;
        for (int a = 0; a < 4; a++)
            for (int b = 0; b < BIN_N; b++)
            begin
                r = 1.0 + real'(b) / real'(BIN_STEP);
                t[(a*BIN_N+b)*XW +: XW] = XW'(longint'((r ** al[a] - 1.0) * 65536.0));
            end
        return t;
    endfunction : ovs_build_x

    localparam logic [4*BIN_N*XW-1:0] X_TAB = ovs_build_x();

    // k and c in time units, exponent code
    function automatic logic [2*KW+1:0] ovs_curve(input logic [3:0] c);
        unique case (c)
            CRV_IEC_SI:  return {KW'(int'(0.14*UNITS_PER_S)), KW'(0), 2'h0};
            CRV_IEC_VI:  return {KW'(int'(13.5*UNITS_PER_S)), KW'(0), 2'h2};
            CRV_IEC_EI:  return {KW'(int'(80.0*UNITS_PER_S)), KW'(0), 2'h3};
            CRV_IEC_LTI: return {KW'(int'(120.0*UNITS_PER_S)), KW'(0), 2'h2};
            CRV_FR_STI:  return {KW'(int'(0.05*UNITS_PER_S)), KW'(0), 2'h1};
            CRV_IEEE_MI: return {KW'(int'(0.0515*UNITS_PER_S)),
                                 KW'(int'(0.114*UNITS_PER_S)), 2'h0};
            CRV_IEEE_VI: return {KW'(int'(19.61*UNITS_PER_S)),
                                 KW'(int'(0.491*UNITS_PER_S)), 2'h3};
            CRV_IEEE_EI: return {KW'(int'(28.2*UNITS_PER_S)),
                                 KW'(int'(0.1217*UNITS_PER_S)), 2'h3};
            CRV_US_CO8:  return {KW'(int'(5.848*UNITS_PER_S)),
                                 KW'(int'(0.1654*UNITS_PER_S)), 2'h3};
            CRV_US_STI1: return {KW'(int'(0.02394*UNITS_PER_S)),
                                 KW'(int'(0.01694*UNITS_PER_S)), 2'h0};
            CRV_US_STI2: return {KW'(int'(0.16758*UNITS_PER_S)),
                                 KW'(int'(0.11858*UNITS_PER_S)), 2'h0};
            default:     return {KW'(int'(0.14*UNITS_PER_S)), KW'(0), 2'h0};
        endcase
    endfunction : ovs_curve
endpackage : ovs_pkg

// ---- src/ovs_stage_logic.sv ----
// Three-stage overvoltage decision logic with AHB-Lite register slave
`timescale 1ns/1ps
//Behaviour
// - Three stages, own threshold and delay each
// - Stage settings shared by all three phases
// - Select phase-to-phase or phase-to-neutral voltages
// - Stage drives trip and pulse, or alarm
// - Any-phase mode: one phase above threshold
// - All-phases mode: every phase above threshold
// - Breaker-qualified modes also need breaker closed
// - Stages one and two: definite or inverse
// - Stage three: definite time only
// - Inverse time: multiplier times (k/(r^a-1)+c)
// - IEEE/US curves scale by time dial
// - IEC standard inverse constants
// - IEC very inverse constants
// - IEC extremely inverse constants
// - IEC long time inverse constants
// - FR short time inverse constants
// - IEEE moderately inverse constants
// - IEEE very inverse constants
// - IEEE extremely inverse constants
// - US time inverse constants
// - US short time inverse, first variant
// - US short time inverse, second variant
// - Timer resets below 95 percent threshold
module ovs_stage_logic (
    // Clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic      [31:0]     hrdata,
    output logic                 hreadyout,
    output logic                 hresp,
    // Measured voltages
    input  wire logic [15:0]     volt_an,
    input  wire logic [15:0]     volt_bn,
    input  wire logic [15:0]     volt_cn,
    input  wire logic [15:0]     volt_ab,
    input  wire logic [15:0]     volt_bc,
    input  wire logic [15:0]     volt_ca,
    input  wire logic            breaker_closed_contact,
    // Protection outputs
    output logic                 prot_trip,
    output logic                 trip_pulse,
    output logic                 alarm
);
    localparam int VW = ovs_pkg::VW;
    localparam int NS = ovs_pkg::NSTG;
    localparam int NI = ovs_pkg::NIDMT;

    logic [ovs_pkg::CTL_W-1:0]  ctrl_q [NS];
    logic [VW-1:0]              thr_q  [NS];
    logic [ovs_pkg::DLY_W-1:0]  dly_q  [NS];
    logic [ovs_pkg::MUL_W-1:0]  mul_q  [NS];
    logic                       ph_ph_q;
    logic [2:0]                 pu_q   [NS];
    logic [NS-1:0]              cond;
    logic [NS-1:0]              op_q;
    logic [NS-1:0]              act_alarm;
    logic [NS-1:0]              use_idmt;
    logic [10:0]                sub_q  [NS];
    logic [31:0]                units_q [NS];
    logic [31:0]                need   [NS];
    logic [31:0]                t_inv_q [NI];
    logic [4:0]                 bin    [NI];
    logic [5:0]                 dcnt_q [NI];
    logic [ovs_pkg::NUMW-1:0]   num_q  [NI];
    logic [ovs_pkg::XW:0]       rem_q  [NI];
    logic [ovs_pkg::XW-1:0]     den_q  [NI];
    logic [ovs_pkg::KW-1:0]     cadd_q [NI];
    logic [VW-1:0]              g      [3];
    logic [VW-1:0]              g_max;
    logic [VW-1:0]              g_min;
    logic                       trip_d;
    logic                       prot_trip_q;
    logic                       trip_pulse_q;
    logic                       alarm_q;
    logic                       wr_q;
    logic [7:0]                 waddr_q;

    function automatic logic [VW-1:0] vmax(input logic [VW-1:0] a, b);
        return (a > b) ? a : b;
    endfunction : vmax

    function automatic logic [VW-1:0] vmin(input logic [VW-1:0] a, b);
        return (a < b) ? a : b;
    endfunction : vmin

    // Ratio bin: largest i with g >= gs * (1 + i/8)
    function automatic logic [4:0] ratio_bin(input logic [VW-1:0] gv, gs);
        logic [VW+4:0] lhs;
        logic [4:0]    b;
        lhs = {2'h0, gv, 3'h0};
        b = 5'h00;
        for (int i = 1; i < ovs_pkg::BIN_N; i++)
            if (lhs >= (VW+5)'(gs) * (VW+5)'(ovs_pkg::BIN_STEP + i))
                b = 5'(i);
        return b;
    endfunction : ratio_bin

    // Register index decode: stage blocks at 0x10, 0x20, 0x30
    function automatic logic [1:0] stg_idx(input logic [7:0] a);
        return a[5:4] - 2'h1;
    endfunction : stg_idx

    function automatic logic is_stg(input logic [7:0] a);
        return (a[7:6] == 2'h0) && (a[5:4] != 2'h0);
    endfunction : is_stg

    function automatic logic [31:0] rd_word(input logic [7:0] a);
        logic [1:0] s;
        s = stg_idx(a);
        if (a == ovs_pkg::OFS_GLOBAL)
            return {31'h0, ph_ph_q};
        if (a == ovs_pkg::OFS_STATUS)
            return {24'h0, alarm_q, prot_trip_q, |pu_q[2], |pu_q[1], |pu_q[0], op_q};
        if (!is_stg(a))
            return 32'h0;
        unique case (a[3:2])
            ovs_pkg::FLD_CTRL:   return {20'h0, ctrl_q[s]};
            ovs_pkg::FLD_THRESH: return {16'h0, thr_q[s]};
            ovs_pkg::FLD_DELAY:  return {8'h0, dly_q[s]};
            ovs_pkg::FLD_MULT:   return {16'h0, mul_q[s]};
        endcase
    endfunction : rd_word

    // Bus slave: zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_q    <= 1'b0;
            waddr_q <= 8'h00;
            hrdata  <= 32'h0;
        end
        else if (hready)
        begin
            wr_q    <= hsel && htrans[1] && hwrite;
            waddr_q <= haddr[7:0];
            if (hsel && htrans[1] && !hwrite)
                hrdata <= rd_word(haddr[7:0]);
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ph_ph_q <= 1'b0;
            for (int s = 0; s < NS; s++)
            begin
                ctrl_q[s] <= ovs_pkg::RST_CTRL;
                thr_q[s]  <= ovs_pkg::RST_THRESH;
                dly_q[s]  <= ovs_pkg::RST_DELAY;
                mul_q[s]  <= ovs_pkg::RST_MULT;
            end
        end
        else if (wr_q)
        begin
            if (waddr_q == ovs_pkg::OFS_GLOBAL)
                ph_ph_q <= hwdata[0];
            if (is_stg(waddr_q) && stg_idx(waddr_q) < 2'(NS))
            begin
                unique case (waddr_q[3:2])
                    ovs_pkg::FLD_CTRL:
                    begin
                        ctrl_q[stg_idx(waddr_q)] <= hwdata[ovs_pkg::CTL_W-1:0];
                        if (stg_idx(waddr_q) == 2'(NS-1))
                            ctrl_q[NS-1][ovs_pkg::CTL_IDMT] <= 1'b0;
                    end
                    ovs_pkg::FLD_THRESH: thr_q[stg_idx(waddr_q)] <= hwdata[VW-1:0];
                    ovs_pkg::FLD_DELAY:  dly_q[stg_idx(waddr_q)] <= hwdata[ovs_pkg::DLY_W-1:0];
                    ovs_pkg::FLD_MULT:   mul_q[stg_idx(waddr_q)] <= hwdata[ovs_pkg::MUL_W-1:0];
                endcase
            end
        end
    end

    // Measured quantity select
    always_comb
    begin
        g[0] = ph_ph_q ? volt_ab : volt_an;
        g[1] = ph_ph_q ? volt_bc : volt_bn;
        g[2] = ph_ph_q ? volt_ca : volt_cn;
        g_max = vmax(g[0], vmax(g[1], g[2]));
        g_min = vmin(g[0], vmin(g[1], g[2]));
    end

    // Per-phase pickup with drop-off at 95 percent
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            for (int s = 0; s < NS; s++)
                pu_q[s] <= 3'h0;
        else
            for (int s = 0; s < NS; s++)
                for (int p = 0; p < ovs_pkg::NPH; p++)
                    if (g[p] > thr_q[s])
                        pu_q[s][p] <= 1'b1;
                    else if ((VW+5)'(g[p]) * (VW+5)'(ovs_pkg::HYST_DEN)
                             < (VW+5)'(thr_q[s]) * (VW+5)'(ovs_pkg::HYST_NUM))
                        pu_q[s][p] <= 1'b0;
    end

    // Stage operate conditions
    always_comb
    begin
        for (int s = 0; s < NS; s++)
        begin
            act_alarm[s] = ctrl_q[s][ovs_pkg::CTL_ALARM];
            use_idmt[s]  = ctrl_q[s][ovs_pkg::CTL_IDMT] && (s < NI);
            unique case (ctrl_q[s][ovs_pkg::CTL_MODE_LO +: 3])
                ovs_pkg::OVS_ANY:    cond[s] = |pu_q[s];
                ovs_pkg::OVS_ALL:    cond[s] = &pu_q[s];
                ovs_pkg::OVS_ANY_BQ: cond[s] = |pu_q[s] && breaker_closed_contact;
                ovs_pkg::OVS_ALL_BQ: cond[s] = &pu_q[s] && breaker_closed_contact;
                default:             cond[s] = 1'b0;
            endcase
        end
    end

    // Inverse time: serial divider per inverse-capable stage
    always_comb
    begin
        for (int i = 0; i < NI; i++)
        begin
            if (ctrl_q[i][ovs_pkg::CTL_MODE_LO +: 3] == ovs_pkg::OVS_ALL
                || ctrl_q[i][ovs_pkg::CTL_MODE_LO +: 3] == ovs_pkg::OVS_ALL_BQ)
                bin[i] = ratio_bin(g_min, thr_q[i]);
            else
                bin[i] = ratio_bin(g_max, thr_q[i]);
        end
    end

    // Recomputed every few dozen cycles so the delay tracks the voltage
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            for (int i = 0; i < NI; i++)
            begin
                dcnt_q[i]  <= 6'h00;
                num_q[i]   <= '0;
                rem_q[i]   <= '0;
                den_q[i]   <= '0;
                cadd_q[i]  <= '0;
                t_inv_q[i] <= 32'hFFFFFFFF;
            end
        else
            for (int i = 0; i < NI; i++)
            begin
                logic [2*ovs_pkg::KW+1:0] cv;
                logic [ovs_pkg::XW:0]     r2;
                logic [63:0]              tm;
                cv = ovs_pkg::ovs_curve(ctrl_q[i][ovs_pkg::CTL_CRV_LO +: 4]);
                r2 = {rem_q[i][ovs_pkg::XW-1:0], num_q[i][ovs_pkg::NUMW-1]};
                tm = 64'(32'(num_q[i]) + 32'(cadd_q[i])) * 64'(mul_q[i]);
                if (dcnt_q[i] == 6'h00)
                begin
                    // Previous quotient is complete here; ratio at 1.0 never times out
                    t_inv_q[i] <= (den_q[i] == '0 || |tm[63:40]) ? 32'hFFFFFFFF
                                  : tm[39:8];
                    // Load k scaled by 2^16 over (r^alpha - 1) in Q16
                    num_q[i]  <= {cv[2*ovs_pkg::KW+1 -: ovs_pkg::KW], ovs_pkg::XFRAC'(0)};
                    den_q[i]  <= ovs_pkg::X_TAB[(int'(cv[1:0]) * ovs_pkg::BIN_N
                                                 + int'(bin[i])) * ovs_pkg::XW +: ovs_pkg::XW];
                    cadd_q[i] <= cv[ovs_pkg::KW+1 -: ovs_pkg::KW];
                    rem_q[i]  <= '0;
                    dcnt_q[i] <= 6'(ovs_pkg::NUMW);
                end
                else
                begin
                    if (r2 >= {1'b0, den_q[i]})
                    begin
                        rem_q[i] <= r2 - {1'b0, den_q[i]};
                        num_q[i] <= {num_q[i][ovs_pkg::NUMW-2:0], 1'b1};
                    end
                    else
                    begin
                        rem_q[i] <= r2;
                        num_q[i] <= {num_q[i][ovs_pkg::NUMW-2:0], 1'b0};
                    end
                    dcnt_q[i] <= dcnt_q[i] - 6'h01;
                end
            end
    end

    // Inverse time lags a voltage step by up to two divider runs
    always_comb
    begin
        for (int s = 0; s < NS; s++)
            need[s] = 32'(dly_q[s]);
        for (int i = 0; i < NI; i++)
            if (use_idmt[i])
                need[i] = t_inv_q[i];
    end

    // Delay timers in time units
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            for (int s = 0; s < NS; s++)
            begin
                sub_q[s]   <= 11'h000;
                units_q[s] <= 32'h0;
                op_q[s]    <= 1'b0;
            end
        else
            for (int s = 0; s < NS; s++)
                if (!cond[s])
                begin
                    sub_q[s]   <= 11'h000;
                    units_q[s] <= 32'h0;
                    op_q[s]    <= 1'b0;
                end
                else
                begin
                    if (sub_q[s] == 11'(ovs_pkg::UNIT_CYC - 1))
                    begin
                        sub_q[s] <= 11'h000;
                        if (units_q[s] != 32'hFFFFFFFF)
                            units_q[s] <= units_q[s] + 32'h1;
                    end
                    else
                        sub_q[s] <= sub_q[s] + 11'h001;
                    if (units_q[s] >= need[s] && need[s] != 32'hFFFFFFFF)
                        op_q[s] <= 1'b1;
                end
    end

    // Outputs
    assign trip_d = |(op_q & ~act_alarm);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            prot_trip_q  <= 1'b0;
            trip_pulse_q <= 1'b0;
            alarm_q      <= 1'b0;
        end
        else
        begin
            prot_trip_q  <= trip_d;
            trip_pulse_q <= trip_d && !prot_trip_q;
            alarm_q      <= |(op_q & act_alarm);
        end
    end

    assign prot_trip  = prot_trip_q;
    assign trip_pulse = trip_pulse_q;
    assign alarm      = alarm_q;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_trip_from_trip: assert property (prot_trip |-> $past(|(op_q & ~act_alarm)))
        else $error("trip without a trip stage operated");
    a_alarm_from_alarm: assert property (alarm |-> $past(|(op_q & act_alarm)))
        else $error("alarm without an alarm stage operated");
    a_pulse_on_rise: assert property ($rose(prot_trip) |-> trip_pulse ##1 !trip_pulse)
        else $error("trip pulse not a single cycle at trip rise");
    a_third_dt_only: assert property (!ctrl_q[NS-1][ovs_pkg::CTL_IDMT])
        else $error("stage three holds inverse selection");
    a_any_phase_op: assert property (
        ctrl_q[0][2:0] == ovs_pkg::OVS_ANY && pu_q[0] != 3'h0 |-> cond[0])
        else $error("any-phase stage not picked up");
    a_all_phase_op: assert property (
        ctrl_q[0][2:0] == ovs_pkg::OVS_ALL && pu_q[0] != 3'h7 |-> !cond[0])
        else $error("all-phases stage picked up with a healthy phase");
    a_breaker_gate: assert property (
        ctrl_q[1][2:0] >= ovs_pkg::OVS_ANY_BQ && !breaker_closed_contact |-> !cond[1])
        else $error("breaker-qualified stage picked up with breaker open");
    a_drop_resets: assert property (
        pu_q[0][0] && 21'(g[0]) * 21'(ovs_pkg::HYST_DEN) < 21'(thr_q[0]) * 21'(ovs_pkg::HYST_NUM)
        |=> !pu_q[0][0] ##1 ($past(cond[0]) || units_q[0] == 32'h0))
        else $error("pickup not reset below drop-off level");
    a_op_after_delay: assert property (
        $rose(op_q[2]) |-> $past(cond[2]) && $past(units_q[2]) >= 32'(dly_q[2]))
        else $error("stage three operated before its delay");
    a_op_drops: assert property (!cond[0] |=> !op_q[0])
        else $error("stage one still operated after pickup lost");

    c_trip: cover property ($rose(prot_trip));
    c_alarm: cover property ($rose(alarm));
    c_idmt_op: cover property (use_idmt[0] && $rose(op_q[0]));
    c_bq_block: cover property (cond[1] ##1 !breaker_closed_contact);
endmodule : ovs_stage_logic

// ---- testbench/ovs_front_end_model.sv ----
// Front-end model: six voltage magnitudes and the breaker contact
`timescale 1ns/1ps
module ovs_front_end_model (
    // Clock
    input  wire logic        hclk,
    // Levels asked for by the bench, phase a in the low bits
    input  wire logic [47:0] lvl_n,
    input  wire logic [47:0] lvl_p,
    input  wire logic        brk,
    // Outputs, refreshed once per clock like a sampling converter
    output logic      [15:0] volt_an,
    output logic      [15:0] volt_bn,
    output logic      [15:0] volt_cn,
    output logic      [15:0] volt_ab,
    output logic      [15:0] volt_bc,
    output logic      [15:0] volt_ca,
    output logic             breaker_closed_contact
);
    always_ff @(posedge hclk)
    begin
        {volt_cn, volt_bn, volt_an} <= lvl_n;
        {volt_ca, volt_bc, volt_ab} <= lvl_p;
        breaker_closed_contact      <= brk;
    end
endmodule : ovs_front_end_model

// ---- testbench/ovs_stage_logic_tb.sv ----
// Self-checking bench for the overvoltage stage logic
`timescale 1ns/1ps
module ovs_stage_logic_tb;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [47:0] lvl_n = '0;
    logic [47:0] lvl_p = '0;
    logic        brk = 1'b0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic [15:0] v_an, v_bn, v_cn, v_ab, v_bc, v_ca;
    logic        brk_c, prot_trip, trip_pulse, alarm;
    int          bad_count = 0;
    int          num_checks = 0;
    int          s, md, n;
    logic [31:0] seed = 32'hC6A35C8F;
    logic [31:0] rd;
    logic [15:0] thr;
    logic [2:0]  m;
    logic        g, al, e;
    always #25 hclk = ~hclk;
    ovs_front_end_model fe (.hclk(hclk), .lvl_n(lvl_n), .lvl_p(lvl_p), .brk(brk),
        .volt_an(v_an), .volt_bn(v_bn), .volt_cn(v_cn), .volt_ab(v_ab), .volt_bc(v_bc),
        .volt_ca(v_ca), .breaker_closed_contact(brk_c));
    ovs_stage_logic uut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .volt_an(v_an), .volt_bn(v_bn), .volt_cn(v_cn), .volt_ab(v_ab), .volt_bc(v_bc),
        .volt_ca(v_ca), .breaker_closed_contact(brk_c), .prot_trip(prot_trip),
        .trip_pulse(trip_pulse), .alarm(alarm));
    task automatic tally_and_finish;
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // A slave that never answers must not hang the run
    task automatic wait_rdy;
        int k;
        k = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            if (++k > 16)
            begin
                bad_count++;
                tally_and_finish();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        haddr  <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic cfg(input int st, input logic [11:0] c, input logic [23:0] dly);
        bus(1'b1, 8'(16 * st), {20'h00000, c});
        bus(1'b1, 8'(16 * st + 4), {16'h0000, thr});
        bus(1'b1, 8'(16 * st + 8), {8'h00, dly});
    endtask : cfg
    task automatic wait_trip(input int lim);
        n = 0;
        while (prot_trip !== 1'b1 && n < lim)
        begin
            @(posedge hclk);
            n++;
        end
        if (n >= lim)
        begin
            bad_count++;
            tally_and_finish();
        end
    endtask : wait_trip
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xs
    // Raised phases sit just above threshold, others well under the drop-off
    function automatic logic [47:0] lv(input logic [2:0] mk, input logic [31:0] r);
        logic [47:0] v;
        for (int k = 0; k < 3; k++)
            v[16*k +: 16] = mk[k] ? thr + 16'(r[8*k +: 6]) + 16'h0001 : thr >> 1;
        return v;
    endfunction : lv
    function automatic logic op_exp(input int mo, input logic [2:0] mk, input logic b);
        case (mo)
            1: return |mk;
            2: return &mk;
            3: return (|mk) & b;
            4: return (&mk) & b;
            default: return 1'b0;
        endcase
    endfunction : op_exp
    initial
    begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h00000000);
        bus(1'b0, 8'h34, 32'h0);
        chk(rd, 32'h0000FFFF);
        bus(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h00000100);
        bus(1'b0, 8'h80, 32'h0);
        chk(rd, 32'h00000000);
        // Pulse, strict threshold and 95 percent drop-off on stage three
        thr = 16'd1000;
        cfg(3, 12'h001, 24'h0);
        lvl_n <= {32'h0, 16'd1001};
        wait_trip(10);
        chk(trip_pulse, 1'b1);
        @(posedge hclk);
        chk(trip_pulse, 1'b0);
        lvl_n <= {32'h0, 16'd960};
        repeat (8) @(posedge hclk);
        chk(prot_trip, 1'b1);
        lvl_n <= {32'h0, 16'd940};
        repeat (8) @(posedge hclk);
        chk(prot_trip, 1'b0);
        lvl_n <= {32'h0, 16'd1000};
        repeat (8) @(posedge hclk);
        chk(prot_trip, 1'b0);
        // Inverse request: near-unity ratio holds stage one, stage three ignores it
        lvl_n <= '0;
        cfg(3, 12'h000, 24'h0);
        cfg(1, 12'h021, 24'h0);
        lvl_n <= {32'h0, 16'd1001};
        repeat (40) @(posedge hclk);
        chk(prot_trip, 1'b0);
        cfg(1, 12'h000, 24'h0);
        cfg(3, 12'h021, 24'h0);
        wait_trip(10);
        chk(prot_trip, 1'b1);
        lvl_n <= '0;
        cfg(3, 12'h000, 24'h0);
        // Zero multiplier: inverse stage one operates at once above 1.125
        cfg(1, 12'h021, 24'h0);
        bus(1'b1, 8'h1C, 32'h0);
        lvl_n <= {32'h0, 16'd2000};
        wait_trip(300);
        chk(prot_trip, 1'b1);
        lvl_n <= '0;
        cfg(1, 12'h000, 24'h0);
        // One 100 us unit of definite delay on stage two
        cfg(2, 12'h001, 24'h1);
        repeat (4) @(posedge hclk);
        lvl_n <= {32'h0, 16'd1001};
        wait_trip(2100);
        chk(32'(n >= 2001 && n <= 2008), 32'h1);
        lvl_n <= '0;
        cfg(2, 12'h000, 24'h0);
        // Random stage, mode, role, voltage type, phases and breaker
        for (int i = 0; i < 40; i++)
        begin
            seed = xs(seed);
            s = int'(seed[1:0]) % 3 + 1;
            md = int'(seed[9:7]) % 5;
            {g, al, m, brk} <= {seed[5], seed[6], seed[12:10], seed[13]};
            thr = 16'h0400 + 16'(seed[23:16]);
            bus(1'b1, 8'h00, {31'h0, seed[5]});
            cfg(s, {7'h00, seed[6], 1'b0, 3'(md)}, 24'h0);
            lvl_n <= lv(g ? ~m : m, xs(seed));
            lvl_p <= lv(g ? m : ~m, xs(seed));
            repeat (8) @(posedge hclk);
            e = op_exp(md, m, brk);
            chk(prot_trip, e & ~al);
            chk(alarm, e & al);
            lvl_n <= '0;
            lvl_p <= '0;
            repeat (6) @(posedge hclk);
            chk({prot_trip, alarm}, 2'b00);
            bus(1'b1, 8'(16 * s), 32'h0);
        end
        tally_and_finish();
    end
endmodule : ovs_stage_logic_tb
